/* File: src/ibd_port.sv */
// Byte-wide indexed data register access port of the host bus interface
`timescale 1ns/100ps
// Overview of operation
// - Read drives addressed byte of the internal register on d[7:0] while read active.
// - Write captures d[7:0] at the trailing edge of the write strobe.
// - Upper lanes d[15:8] are never sampled nor driven; enable stays low.
// - Mixed reads and writes at one index, each covering all four bytes.
// - Bytes of a word are accepted in any order.
module ibd_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic fifo_direct_select,
  input wire logic [ibd_pkg::IBD_ADDR_W-1:0] addr,
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic [1:0] d_oe,
  input wire logic [ibd_pkg::IBD_NUM_IDX*ibd_pkg::IBD_IDX_W-1:0] index_val,
  input wire logic [ibd_pkg::IBD_WORD_W-1:0] reg_rdata,
  output logic [ibd_pkg::IBD_IDX_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [ibd_pkg::IBD_WORD_W-1:0] reg_wdata
);
  import ibd_pkg::*;

  // ==========================================================
  // Pin synchronisation
  // Strobes, select, address and low data lanes all cross from the pins;
  // upper data lanes are left out so they can never be sampled
  logic [16:0] pins_s;
  ibd_sync #(.W(17)) u_sync (
    .clk(clk),
    .srst(srst),
    .din({cs, rd, wr, fifo_direct_select, addr, d_in[7:0]}),
    .dout(pins_s)
  );
  logic cs_s, rd_s, wr_s, fsel_s;
  logic [4:0] addr_s;
  logic [7:0] din_s;
  assign {cs_s, rd_s, wr_s, fsel_s, addr_s, din_s} = pins_s;

  // Decode: data register window with fifo select low
  logic hit;
  logic [4:0] off;
  logic [1:0] sel;
  logic [1:0] lane;
  assign off = addr_s - IBD_DATA_BASE;
  assign hit = cs_s && !fsel_s && (addr_s >= IBD_DATA_BASE) && (off[4:2] < 3'(IBD_NUM_IDX));
  assign sel = off[3:2];
  assign lane = off[1:0];

  // ==========================================================
  // Access state
  // Read and write progress are kept apart so a mixed sequence
  // at one index never confuses a partial read with a partial write
  ibd_state_e state_r, state_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic [3:0] seen_r, seen_nxt;
  logic [3:0] wseen_r, wseen_nxt;
  logic [31:0] stage_r, stage_nxt;
  logic [31:0] wstage_r, wstage_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic [31:0] raddr_r, raddr_nxt;
  logic rrd_r, rrd_nxt;
  logic rwr_r, rwr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] idx_pick;

  assign idx_pick = index_val[sel*IBD_IDX_W +: IBD_IDX_W];

  // One-hot mask of the byte lane held for the current strobe
  logic [3:0] lane_hot;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_hot[g] = (lane_r == 2'(g));
  end

  // Lane sets including the byte of the strobe now ending
  logic [3:0] seen_upd;
  logic [3:0] wseen_upd;
  assign seen_upd = seen_r | lane_hot;
  assign wseen_upd = wseen_r | lane_hot;

  // Word that the read byte comes from: bus data on the fetch cycle, else staging
  logic [31:0] rword;
  assign rword = rrd_r ? reg_rdata : stage_r;

  // ==========================================================
  // Strobe tracking and staging
  // Next-state logic for strobe tracking, staging and internal bus
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    lane_nxt = lane_r;
    seen_nxt = seen_r;
    wseen_nxt = wseen_r;
    stage_nxt = stage_r;
    wstage_nxt = wstage_r;
    dout_nxt = dout_r;
    oe_nxt = 1'b0;
    raddr_nxt = raddr_r;
    rrd_nxt = 1'b0;
    rwr_nxt = 1'b0;
    wdata_nxt = wdata_r;
    case (state_r)
      IBD_IDLE: begin
        // Refused strobes leave the state untouched
        if (hit && rd_s) begin
          state_nxt = IBD_READ;
          sel_nxt = sel;
          lane_nxt = lane;
          // Fresh word fetched when no read word is in progress
          if (seen_r == IBD_LANES_NONE || sel != sel_r) begin
            raddr_nxt = idx_pick;
            rrd_nxt = 1'b1;
            seen_nxt = IBD_LANES_NONE;
          end
        end else if (hit && wr_s) begin
          state_nxt = IBD_WRITE;
          sel_nxt = sel;
          lane_nxt = lane;
          // Another data register drops the partial word
          if (sel != sel_r) begin
            wseen_nxt = IBD_LANES_NONE;
          end
        end
      end
      IBD_READ: begin
        // Word arrives in the cycle of the fetch pulse and is staged
        if (rrd_r) begin
          stage_nxt = reg_rdata;
        end
        // Addressed byte of the word, held on the lanes while the strobe stands
        dout_nxt = 8'(rword >> {lane_r, 3'b000});
        // Output enable follows the synced strobe and select
        oe_nxt = rd_s && cs_s;
        if (!rd_s || !cs_s) begin
          state_nxt = IBD_IDLE;
          seen_nxt = seen_upd;
          // All four lanes read: next read fetches a fresh word
          if (seen_upd == IBD_LANES_ALL) begin
            seen_nxt = IBD_LANES_NONE;
          end
        end
      end
      IBD_WRITE: begin
        // Trailing edge of the write strobe captures the byte
        if (!wr_s || !cs_s) begin
          state_nxt = IBD_IDLE;
          wstage_nxt[lane_r*8 +: 8] = din_s;
          wseen_nxt = wseen_upd;
          // Fourth distinct lane: hand the whole word to the register bus
          if (wseen_upd == IBD_LANES_ALL) begin
            wdata_nxt = wstage_r;
            wdata_nxt[lane_r*8 +: 8] = din_s;
            raddr_nxt = index_val[sel_r*IBD_IDX_W +: IBD_IDX_W];
            rwr_nxt = 1'b1;
            wseen_nxt = IBD_LANES_NONE;
          end
        end
      end
      // Unused encoding falls back to idle
      default: begin
        state_nxt = IBD_IDLE;
      end
    endcase
    // Synchronous reset returns every field to its idle value
    if (srst) begin
      state_nxt = IBD_IDLE;
      sel_nxt = 2'h0;
      lane_nxt = 2'h0;
      seen_nxt = IBD_LANES_NONE;
      wseen_nxt = IBD_LANES_NONE;
      stage_nxt = IBD_WORD_RST;
      wstage_nxt = IBD_WORD_RST;
      dout_nxt = 8'h00;
      oe_nxt = 1'b0;
      raddr_nxt = IBD_WORD_RST;
      rrd_nxt = 1'b0;
      rwr_nxt = 1'b0;
      wdata_nxt = IBD_WORD_RST;
    end
  end

  // ==========================================================
  // Register stage
  // Register all access state
  always_ff @(posedge clk) begin
    state_r <= state_nxt;
    sel_r <= sel_nxt;
    lane_r <= lane_nxt;
    seen_r <= seen_nxt;
    wseen_r <= wseen_nxt;
    stage_r <= stage_nxt;
    wstage_r <= wstage_nxt;
    dout_r <= dout_nxt;
    oe_r <= oe_nxt;
    raddr_r <= raddr_nxt;
    rrd_r <= rrd_nxt;
    rwr_r <= rwr_nxt;
    wdata_r <= wdata_nxt;
  end

  // ==========================================================
  // Outputs
  // Upper lanes stay released and zero in byte-wide mode
  assign d_out = {8'h00, dout_r};
  assign d_oe = {1'b0, oe_r};
  // Internal register bus comes straight from flip-flops
  assign reg_addr = raddr_r;
  assign reg_rd = rrd_r;
  assign reg_wr = rwr_r;
  assign reg_wdata = wdata_r;
endmodule

/* File: include/ibd_pkg.sv */
// Constants and types for the indexed byte-wide data register port
package ibd_pkg;
  localparam int IBD_DATA_W = 8;
  localparam int IBD_ADDR_W = 5;
  localparam int IBD_IDX_W = 32;
  localparam int IBD_WORD_W = 32;
  localparam int IBD_NUM_IDX = 3;
  // Address of lowest byte of data register n is DATA_BASE + 4*n
  localparam logic [4:0] IBD_DATA_BASE = 5'h0C;
  localparam logic [3:0] IBD_LANES_ALL = 4'hF;
  localparam logic [3:0] IBD_LANES_NONE = 4'h0;
  localparam logic [31:0] IBD_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] IBD_SYNC_RST = 2'h0;
  typedef enum logic [1:0] {
    IBD_IDLE,
    IBD_READ,
    IBD_WRITE
  } ibd_state_e;
endpackage

/* File: src/ibd_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/100ps
module ibd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  // Next values: first stage only feeds the second
  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
    if (srst) begin
      meta_nxt = '0;
      dout_nxt = '0;
    end
  end

  // Register stages
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    dout <= dout_nxt;
  end
endmodule

/* File: verification/ibd_port_asserts.sv */
// Concurrent checks on the ports of the byte-wide data register port
`timescale 1ns/100ps
module ibd_port_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic fifo_direct_select,
  input wire logic [15:0] d_out,
  input wire logic [1:0] d_oe,
  input wire logic reg_rd,
  input wire logic reg_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Read strobe released long enough to pass the synchroniser
  sequence rd_idle;
    !rd [*4];
  endsequence
  a_upper_lanes_off: assert property (d_oe[1] == 1'b0 && d_out[15:8] == 8'h00)
    else $error("upper lanes active");
  a_read_drives: assert property ($rose(reg_rd) |-> ##[1:2] d_oe[0])
    else $error("read data not driven");
  a_read_release: assert property (rd_idle |-> !d_oe[0])
    else $error("lanes driven after read");
  a_fetch_cause: assert property (reg_rd |-> $past(rd, 2) && $past(cs, 2))
    else $error("fetch without read");
  a_commit_after: assert property (reg_wr |-> !$past(wr, 2))
    else $error("commit before strobe end");
  a_pulse_single: assert property (reg_rd || reg_wr |=> !reg_rd && !reg_wr)
    else $error("pulse too long");
  a_fifo_ignored: assert property (fifo_direct_select [*4] |-> !reg_rd && !reg_wr)
    else $error("fifo select access taken");
endmodule
bind ibd_port ibd_port_asserts ibd_port_asserts_i (.clk, .srst, .cs, .rd, .wr,
  .fifo_direct_select, .d_out, .d_oe, .reg_rd, .reg_wr);

/* File: verification/ibd_host.sv */
// Host processor model driving the byte-wide port pins
`timescale 1ns/100ps
module ibd_host (
  input wire logic clk,
  input wire logic [15:0] d_out,
  input wire logic [1:0] d_oe,
  output logic cs,
  output logic rd,
  output logic wr,
  output logic fifo_direct_select,
  output logic [4:0] addr,
  output logic [15:0] d_in
);
  // Pins idle at time zero
  initial begin
    {cs, rd, wr, fifo_direct_select, addr} = '0;
    d_in = 16'h0000;
  end
  // One byte cycle; strobe five clocks high (reads: five after d_oe rises), five low, released bus inverted
  task automatic cyc(input logic w, input logic fs, input logic [4:0] a,
    input logic [7:0] wd, output logic [7:0] rb);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cs = 1;
    fifo_direct_select = fs;
    addr = a;
    d_in = w ? {~d_in[15:8], wd} : ~d_in;
    if (w) wr = 1; else rd = 1;
    while (!w && d_oe[0] !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    repeat (5) @(posedge clk);
    #1;
    rb = d_out[7:0];
    {rd, wr} = 2'h0;
    repeat (5) @(posedge clk);
    #1;
    {cs, fifo_direct_select} = 2'h0;
    d_in = ~d_in;
  endtask
endmodule

/* File: verification/ibd_port_bench.sv */
// Self-checking bench for the byte-wide data register port
`timescale 1ns/100ps
module ibd_port_bench;
  import ibd_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic cs, rd, wr, fifo_direct_select, reg_rd, reg_wr;
  logic [4:0] addr;
  logic [15:0] d_in, d_out;
  logic [1:0] d_oe;
  logic [95:0] index_val = {32'h0000_0300, 32'h0000_0200, 32'h0000_0100};
  logic [31:0] reg_rdata;
  logic [31:0] reg_addr, reg_wdata;
  logic [31:0] mem [4] = '{32'h0000_0000, 32'hA1B2_C3D4, 32'h5566_7788, 32'h0F1E_2D3C};
  int n_mismatch = 0, samples_checked = 0, wr_cnt = 0, rd_cnt = 0, cyc_n = 0;
  always #50 clk = ~clk;
  ibd_port ibd_port_i (.clk, .srst, .cs, .rd, .wr, .fifo_direct_select, .addr, .d_in,
    .d_out, .d_oe, .index_val, .reg_rdata, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
  ibd_host ibd_host_i (.clk, .d_out, .d_oe, .cs, .rd, .wr, .fifo_direct_select, .addr,
    .d_in);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Internal register store answers in the cycle of the fetch pulse
  assign reg_rdata = mem[reg_addr[9:8]];
  // Internal register store and cycle ceiling
  always @(posedge clk) begin
    if (reg_rd) rd_cnt <= rd_cnt + 1;
    if (reg_wr) mem[reg_addr[9:8]] <= reg_wdata;
    if (reg_wr) wr_cnt <= wr_cnt + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Four byte cycles of one word, lanes in the order packed in ord
  task automatic word(input int n, input logic w, input logic fs, input logic [31:0] v,
    input logic [7:0] ord);
    logic [7:0] b;
    logic [1:0] ln;
    for (int i = 0; i < 4; i++) begin
      ln = ord[2*i+:2];
      ibd_host_i.cyc(w, fs, 5'(IBD_DATA_BASE + 4 * n + ln), v[8*ln+:8], b);
      if (!w && !fs) check(b, v[8*ln+:8]);
    end
  endtask
  task automatic t_read_order();
    word(1, 0, 0, 32'h5566_7788, 8'b01_11_00_10);
    check(reg_addr, 32'h0000_0200);
  endtask
  task automatic t_write_order();
    int c0;
    c0 = wr_cnt;
    word(2, 1, 0, 32'hCAFE_F00D, 8'b10_00_01_11);
    check(wr_cnt, c0 + 1);
    check(reg_wdata, 32'hCAFE_F00D);
    check(reg_addr, 32'h0000_0300);
  endtask
  task automatic t_mixed();
    word(0, 1, 0, 32'h1357_9BDF, 8'hE4);
    word(0, 0, 0, 32'h1357_9BDF, 8'hE4);
    word(0, 1, 0, 32'h2468_ACE0, 8'h1B);
    word(0, 0, 0, 32'h2468_ACE0, 8'h1B);
  endtask
  task automatic t_refused();
    int c0, r0;
    c0 = wr_cnt;
    r0 = rd_cnt;
    word(0, 1, 1, 32'hFFFF_FFFF, 8'hE4);
    word(0, 0, 1, 32'h0000_0000, 8'hE4);
    check(wr_cnt, c0);
    check(rd_cnt, r0);
    word(0, 0, 0, 32'h2468_ACE0, 8'hE4);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    srst = 0;
    t_read_order();
    t_write_order();
    t_mixed();
    t_refused();
    print_verdict();
  end
endmodule
